// File: hw/sysf_params.svh
/*
  Offsets, field positions, reset values and state codes of the system
  status and fault register bank.
  Assumes inclusion by bare name from the bank module and the bench modules.
*/
`ifndef SYSF_PARAMS_SVH
`define SYSF_PARAMS_SVH

// Register offsets on the register read port
`define SYSF_GS1_ADDR        8'h05
`define SYSF_CONV_ADDR       8'h0d
`define SYSF_FAULT_ADDR      8'h38
`define SYSF_REG_RESET       16'h0000

// General status one field positions
`define SYSF_RATIO_MSB       15
`define SYSF_RATIO_LSB       12
`define SYSF_CAUSE_MSB       7
`define SYSF_CAUSE_LSB       5
`define SYSF_TOP_MSB         4
`define SYSF_TOP_LSB         0

// Reset cause codes
`define SYSF_CAUSE_POWER_ON  3'h0
`define SYSF_CAUSE_PROJ_LOW  3'h1
`define SYSF_CAUSE_WDOG1     3'h2
`define SYSF_CAUSE_WDOG2     3'h3
`define SYSF_CAUSE_OVERTEMP  3'h4
`define SYSF_CAUSE_SW_CYCLE  3'h5

// Top state codes
`define SYSF_ST_SHUTDOWN     5'h00
`define SYSF_ST_INIT_A       5'h01
`define SYSF_ST_OFF          5'h02
`define SYSF_ST_INIT_B       5'h03
`define SYSF_ST_UP_1V1       5'h04
`define SYSF_ST_UP_1V8       5'h05
`define SYSF_ST_UP_3V3       5'h06
`define SYSF_ST_RELEASE_RST  5'h07
`define SYSF_ST_STANDBY      5'h08
`define SYSF_ST_OFFSET_ON    5'h09
`define SYSF_ST_BIAS_ON      5'h0a
`define SYSF_ST_RESET_ON     5'h0b
`define SYSF_ST_DISP_READY   5'h0c
`define SYSF_ST_DISP_ON      5'h0d
`define SYSF_ST_PARK_START   5'h0e
`define SYSF_ST_BIAS_OFF     5'h0f
`define SYSF_ST_OFFSET_OFF   5'h10
`define SYSF_ST_DISCHARGE    5'h11

// Converter block status bit positions
`define SYSF_CONV_STOP       7
`define SYSF_CONV_OVERLAP    6
`define SYSF_CONV_CMD        5
`define SYSF_CONV_PARITY     4
`define SYSF_CONV_CH2_UNDER  3
`define SYSF_CONV_CH2_SAT    2
`define SYSF_CONV_CH1_UNDER  1
`define SYSF_CONV_CH1_SAT    0
`define SYSF_CONV_WIDTH      8

// General fault bit positions
`define SYSF_F_BIAS          15
`define SYSF_F_RESET         14
`define SYSF_F_OFFSET        13
`define SYSF_F_MAIN          12
`define SYSF_F_SUPPLIES      10
`define SYSF_F_CONV_UV       9
`define SYSF_F_CONV_OV       8
`define SYSF_F_GEN_UV        7
`define SYSF_F_GEN_OV        6
`define SYSF_F_REG_OV        5
`define SYSF_F_3V3           2
`define SYSF_F_1V8           1
`define SYSF_F_1V1           0

`endif

// File: hw/sysf_pkg.sv
/*
  Types shared by the status and fault register bank.
  Assumes sysf_params.svh on the include path.
*/
`default_nettype none

package sysf_pkg;

    typedef struct packed {
        logic bias_uv;
        logic reset_uv;
        logic offset_uv;
        logic main_uv;
        logic analog_uv;
        logic s1v1_uv;
        logic s1v8_uv;
        logic s3v3_uv;
        logic s6v_uv;
        logic conv_reg_uv;
        logic conv_reg_ov;
        logic gen_reg_uv;
        logic gen_reg_ov;
        logic reg_ov;
    } sysf_rails_t;

    typedef struct packed {
        logic stop_err;
        logic overlap_err;
        logic cmd_err;
        logic parity_err;
        logic ch2_under;
        logic ch2_sat;
        logic ch1_under;
        logic ch1_sat;
    } sysf_conv_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } sysf_req_t;

    typedef struct packed {
        logic [3:0]  ratio;
        logic [2:0]  cause;
        logic [4:0]  top;
        logic [4:0]  top_prev;
        logic [15:0] fault;
        logic [15:0] rdata;
        logic        rvalid;
        logic        pg_sum;
        logic        conv_sum;
    } sysf_state_t;

endpackage

`default_nettype wire

// File: hw/sysf_flags.sv
/*
  Bank of sticky flags: a set pulse raises a bit, a clear pulse drops all
  bits, and a set in the clearing cycle wins.
  Assumes set pulses synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module sysf_flags #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] set,
    input  wire logic         clr,
    output var  logic [W-1:0] flags_q
);

    logic [W-1:0] flags_d;

    always_comb
    begin
        flags_d = (clr ? '0 : flags_q) | set;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

endmodule

`default_nettype wire

// File: hw/sysf_status_bank.sv
/*
  Read-only system status and fault register bank: general status one,
  converter block status and general fault status, plus the two summary
  flags of the status set register.
  Assumes a serial port front end outside that turns transactions into
  one-cycle read or write strobes with an address, all on mclk.
*/
`timescale 1ns/10ps
`default_nettype none

`include "sysf_params.svh"

//////////////////////////////////////////////////////////////////////////////

module sysf_status_bank
    import sysf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire sysf_req_t   req,
    input  wire logic [3:0]  clk_ratio,
    input  wire logic [4:0]  top_state,
    input  wire logic [2:0]  reset_cause,
    input  wire sysf_conv_t  conv_evt,
    input  wire sysf_rails_t rails,
    output var  logic [15:0] rdata_q,
    output var  logic        rvalid_q,
    output var  logic        pg_fault_sum_q,
    output var  logic        conv_err_sum_q
);

    sysf_state_t s_q;
    sysf_state_t s_d;
    logic [7:0]  conv_set;
    logic [7:0]  conv_q;
    logic        conv_clr;
    logic        enter_off;
    logic [15:0] gs1;
    logic [15:0] conv_reg;
    logic [15:0] fault_now;

    //////////////////////////////////////////////////////////////////////////

    // Command error also latches on every specific command fault
    always_comb
    begin
        conv_set = conv_evt;
        conv_set[`SYSF_CONV_CMD] = conv_evt.cmd_err | conv_evt.stop_err
            | conv_evt.overlap_err | conv_evt.parity_err;
    end

    // Errors are sticky until the register is read, else a short glitch
    // on the converter link would never be seen by software
    assign conv_clr = req.rd && (req.addr == `SYSF_CONV_ADDR);

    sysf_flags #(
        .W (`SYSF_CONV_WIDTH)
    ) u_conv_flags (
        .clk     (mclk),
        .reset_n (reset_n),
        .set     (conv_set),
        .clr     (conv_clr),
        .flags_q (conv_q)
    );

    //////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        fault_now = 16'h0000;
        fault_now[`SYSF_F_BIAS]     = rails.bias_uv;
        fault_now[`SYSF_F_RESET]    = rails.reset_uv;
        fault_now[`SYSF_F_OFFSET]   = rails.offset_uv;
        fault_now[`SYSF_F_MAIN]     = rails.main_uv | rails.analog_uv;
        fault_now[`SYSF_F_SUPPLIES] = rails.s1v1_uv | rails.s1v8_uv
            | rails.s3v3_uv | rails.s6v_uv;
        fault_now[`SYSF_F_CONV_UV]  = rails.conv_reg_uv;
        fault_now[`SYSF_F_CONV_OV]  = rails.conv_reg_ov;
        fault_now[`SYSF_F_GEN_UV]   = rails.gen_reg_uv;
        fault_now[`SYSF_F_GEN_OV]   = rails.gen_reg_ov;
        fault_now[`SYSF_F_REG_OV]   = rails.reg_ov;
        fault_now[`SYSF_F_3V3]      = rails.s3v3_uv;
        fault_now[`SYSF_F_1V8]      = rails.s1v8_uv;
        fault_now[`SYSF_F_1V1]      = rails.s1v1_uv;
    end

    assign enter_off = (top_state == `SYSF_ST_OFF)
        && (s_q.top_prev != `SYSF_ST_OFF);

    // Reserved bits 11 to 8 of status one and 15 to 8 of converter are 0
    assign gs1 = {s_q.ratio, 4'h0, s_q.cause, s_q.top};
    assign conv_reg = {8'h00, conv_q};

    //////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        s_d = s_q;
        s_d.ratio    = clk_ratio;
        s_d.top      = top_state;
        s_d.top_prev = top_state;
        s_d.fault    = fault_now;
        // Codes above the software power cycle are unused and not kept
        if (enter_off && (reset_cause <= `SYSF_CAUSE_SW_CYCLE))
            s_d.cause = reset_cause;
        s_d.pg_sum   = |s_q.fault;
        s_d.conv_sum = |conv_q;
        // Writes are accepted on the port but never alter the bank
        s_d.rvalid   = req.rd;
        s_d.rdata    = 16'h0000;
        if (req.rd)
        begin
            case (req.addr)
                `SYSF_GS1_ADDR:   s_d.rdata = gs1;
                `SYSF_CONV_ADDR:  s_d.rdata = conv_reg;
                `SYSF_FAULT_ADDR: s_d.rdata = s_q.fault;
                default:          s_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign rdata_q        = s_q.rdata;
    assign rvalid_q       = s_q.rvalid;
    assign pg_fault_sum_q = s_q.pg_sum;
    assign conv_err_sum_q = s_q.conv_sum;

    //////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    property p_ratio;
        req.rd && req.addr == `SYSF_GS1_ADDR
            |=> rdata_q[15:12] == $past(clk_ratio, 2);
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("clock ratio field wrong");

    property p_cause;
        enter_off && reset_cause <= `SYSF_CAUSE_SW_CYCLE
            |=> s_q.cause == $past(reset_cause);
    endproperty
    a_cause: assert property (p_cause)
        else $error("reset cause not caught on entry to off");

    property p_cause_range;
        s_q.cause <= `SYSF_CAUSE_SW_CYCLE;
    endproperty
    a_cause_range: assert property (p_cause_range)
        else $error("reset cause holds an unused code");

    property p_top;
        req.rd && req.addr == `SYSF_GS1_ADDR
            |=> rdata_q[4:0] == $past(s_q.top) && rvalid_q;
    endproperty
    a_top: assert property (p_top)
        else $error("top state field wrong");

    sequence s_stop;
        conv_evt.stop_err;
    endsequence
    sequence s_seen;
        conv_q[`SYSF_CONV_STOP] && conv_q[`SYSF_CONV_CMD] ##1 conv_err_sum_q;
    endsequence
    property p_stop;
        s_stop |=> s_seen;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop bit error not flagged");

    property p_overlap;
        conv_evt.overlap_err |=> conv_q[`SYSF_CONV_OVERLAP];
    endproperty
    a_overlap: assert property (p_overlap)
        else $error("overlap error not flagged");

    property p_parity;
        conv_evt.parity_err |=> conv_q[`SYSF_CONV_PARITY]
            && conv_q[`SYSF_CONV_CMD];
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity error not flagged");

    property p_ch2_under;
        conv_evt.ch2_under |=> conv_q[`SYSF_CONV_CH2_UNDER];
    endproperty
    a_ch2_under: assert property (p_ch2_under)
        else $error("channel two underflow not flagged");

    property p_ch2_sat;
        conv_evt.ch2_sat |=> conv_q[`SYSF_CONV_CH2_SAT];
    endproperty
    a_ch2_sat: assert property (p_ch2_sat)
        else $error("channel two saturation not flagged");

    property p_ch1_under;
        conv_evt.ch1_under |=> conv_q[`SYSF_CONV_CH1_UNDER];
    endproperty
    a_ch1_under: assert property (p_ch1_under)
        else $error("channel one underflow not flagged");

    property p_ch1_sat;
        conv_evt.ch1_sat |=> conv_q[`SYSF_CONV_CH1_SAT];
    endproperty
    a_ch1_sat: assert property (p_ch1_sat)
        else $error("channel one saturation not flagged");

    property p_supplies;
        rails.s6v_uv |=> s_q.fault[`SYSF_F_SUPPLIES]
            && s_q.fault[`SYSF_F_3V3] == $past(rails.s3v3_uv);
    endproperty
    a_supplies: assert property (p_supplies)
        else $error("supply OR fault wrong");

    property p_main;
        s_q.fault[`SYSF_F_MAIN] == ($past(rails.main_uv)
            | $past(rails.analog_uv));
    endproperty
    a_main: assert property (p_main)
        else $error("main rail fault wrong");

    property p_pg;
        |fault_now |=> ##1 pg_fault_sum_q;
    endproperty
    a_pg: assert property (p_pg)
        else $error("power good summary missing");

    property p_res_gs1;
        req.rd && req.addr == `SYSF_GS1_ADDR |=> rdata_q[11:8] == 4'h0;
    endproperty
    a_res_gs1: assert property (p_res_gs1)
        else $error("reserved status one bit reads one");

    property p_res_conv;
        req.rd && req.addr == `SYSF_CONV_ADDR |=> rdata_q[15:8] == 8'h00;
    endproperty
    a_res_conv: assert property (p_res_conv)
        else $error("reserved converter bit reads one");

    property p_res_fault;
        req.rd && req.addr == `SYSF_FAULT_ADDR
            |=> rdata_q[11] == 1'b0 && rdata_q[4:3] == 2'b00;
    endproperty
    a_res_fault: assert property (p_res_fault)
        else $error("reserved fault bit reads one");

    property p_unmapped;
        req.rd && req.addr != `SYSF_GS1_ADDR
            && req.addr != `SYSF_CONV_ADDR && req.addr != `SYSF_FAULT_ADDR
            |=> rvalid_q && rdata_q == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped offset reads nonzero");

    // A write alone must never produce an answer on the read port
    property p_idle;
        !req.rd |=> !rvalid_q && rdata_q == 16'h0000;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read port answers without a read");

    property p_conv_clr;
        req.rd && req.addr == `SYSF_CONV_ADDR && conv_set == 8'h00
            |=> conv_q == 8'h00;
    endproperty
    a_conv_clr: assert property (p_conv_clr)
        else $error("converter flags not cleared by read");

    property p_rails_low;
        s_q.fault[`SYSF_F_BIAS] == $past(rails.bias_uv)
            && s_q.fault[`SYSF_F_RESET] == $past(rails.reset_uv)
            && s_q.fault[`SYSF_F_OFFSET] == $past(rails.offset_uv);
    endproperty
    a_rails_low: assert property (p_rails_low)
        else $error("mirror rail fault bit wrong");

    property p_regulators;
        s_q.fault[`SYSF_F_CONV_UV] == $past(rails.conv_reg_uv)
            && s_q.fault[`SYSF_F_CONV_OV] == $past(rails.conv_reg_ov)
            && s_q.fault[`SYSF_F_GEN_UV] == $past(rails.gen_reg_uv)
            && s_q.fault[`SYSF_F_GEN_OV] == $past(rails.gen_reg_ov)
            && s_q.fault[`SYSF_F_REG_OV] == $past(rails.reg_ov);
    endproperty
    a_regulators: assert property (p_regulators)
        else $error("regulator fault bit wrong");

    property p_supply_bits;
        s_q.fault[`SYSF_F_3V3] == $past(rails.s3v3_uv)
            && s_q.fault[`SYSF_F_1V8] == $past(rails.s1v8_uv)
            && s_q.fault[`SYSF_F_1V1] == $past(rails.s1v1_uv);
    endproperty
    a_supply_bits: assert property (p_supply_bits)
        else $error("supply fault bit wrong");

endmodule

`default_nettype wire

// File: tb/sysf_host_model.sv
/*
  Host side of the register read port: issues read and write strobes.
  Assumes the bank answers a read on the same mclk edge that takes it.
*/
`timescale 1ns/10ps
`default_nettype none

`include "sysf_params.svh"

module sysf_host_model
    import sysf_pkg::*;
(
    input  wire logic        mclk,
    output var  sysf_req_t   req,
    input  wire logic [15:0] rdata_q,
    input  wire logic        rvalid_q
);
    initial req = '0;

    //////////////////////////////////////////////////////////////////////
    // Released lines show the inverse so stale values never look valid
    task automatic rd(input logic [7:0] a, input int gap,
                      output logic [15:0] d);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        #1;
        req.addr = a;
        req.rd   = 1'b1;
        @(posedge mclk);
        #1;
        req.rd   = 1'b0;
        req.addr = ~a;
        d = (rvalid_q === 1'b1) ? rdata_q : 16'hxxxx;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        #1;
        req.addr  = a;
        req.wdata = v;
        req.wr    = 1'b1;
        @(posedge mclk);
        #1;
        req.wr    = 1'b0;
        req.addr  = ~a;
        req.wdata = ~v;
    endtask
endmodule

`default_nettype wire

// File: tb/sysf_status_bank_test.sv
/*
  Self-checking bench of the status and fault register bank.
  Assumes the host model drives the read port; bench drives monitors.
*/
`timescale 1ns/10ps
`default_nettype none

`include "sysf_params.svh"

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_fail++; $display("mismatch %s exp %h got %h", n, e, g); end end

module sysf_status_bank_test
    import sysf_pkg::*;
;
    logic        mclk;
    logic        reset_n;
    sysf_req_t   req;
    logic [3:0]  clk_ratio;
    logic [4:0]  top_state;
    logic [2:0]  reset_cause;
    sysf_conv_t  conv_evt;
    sysf_rails_t rails;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic        pg_fault_sum_q;
    logic        conv_err_sum_q;
    int          n_fail;
    int          comparisons;
    int          cyc;
    logic [15:0] ftab [14];

    sysf_status_bank u_sysf_status_bank (
        .mclk(mclk), .reset_n(reset_n), .req(req), .clk_ratio(clk_ratio),
        .top_state(top_state), .reset_cause(reset_cause),
        .conv_evt(conv_evt), .rails(rails), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .pg_fault_sum_q(pg_fault_sum_q),
        .conv_err_sum_q(conv_err_sum_q)
    );

    sysf_host_model u_sysf_host_model (
        .mclk(mclk), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q)
    );

    //////////////////////////////////////////////////////////////////////
    task automatic chk_rd(input string n, input logic [7:0] a,
                          input int gap, input logic [15:0] e);
        logic [15:0] v;
        u_sysf_host_model.rd(a, gap, v);
        `CHK(n, e, v)
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Whole run is well under a thousand cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    //////////////////////////////////////////////////////////////////////
    initial
    begin
        reset_n = 1'b0;
        clk_ratio = 4'h0;
        top_state = 5'h00;
        reset_cause = 3'h0;
        conv_evt = '0;
        rails = '0;
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        ftab = '{16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0200,
                 16'h0400, 16'h0404, 16'h0402, 16'h0401, 16'h1000,
                 16'h1000, 16'h2000, 16'h4000, 16'h8000};
        repeat (3) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        chk_rd("gs1_rst", `SYSF_GS1_ADDR, 0, 16'h0000);
        chk_rd("conv_rst", `SYSF_CONV_ADDR, 0, 16'h0000);
        chk_rd("fault_rst", `SYSF_FAULT_ADDR, 0, 16'h0000);
        // Each cause is latched on a fresh entry to off, slow host too
        clk_ratio = 4'h8;
        for (int c = 0; c < 6; c++)
        begin
            top_state = `SYSF_ST_STANDBY;
            @(posedge mclk);
            #1;
            reset_cause = c[2:0];
            top_state = `SYSF_ST_OFF;
            chk_rd("cause", `SYSF_GS1_ADDR, c,
                   {4'h8, 4'h0, c[2:0], 5'h02});
        end
        // Unused cause code must not replace the stored one
        reset_cause = 3'h7;
        for (int i = 0; i < 18; i++)
        begin
            top_state = i[4:0];
            clk_ratio = ~i[3:0];
            chk_rd("top", `SYSF_GS1_ADDR, 0, {~i[3:0], 4'h0, 3'h5,
                   i[4:0]});
        end
        for (int i = 0; i < 8; i++)
        begin
            conv_evt = sysf_conv_t'(8'h01 << i);
            @(posedge mclk);
            #1;
            conv_evt = '0;
            chk_rd("conv", `SYSF_CONV_ADDR, 0,
                   16'(8'h01 << i) | ((i inside {4, 6, 7}) ? 16'h0020
                   : 16'h0000));
            `CHK("conv_sum", 1'b1, conv_err_sum_q)
            chk_rd("conv_clr", `SYSF_CONV_ADDR, 0, 16'h0000);
            `CHK("conv_sum0", 1'b0, conv_err_sum_q)
        end
        for (int i = 0; i < 14; i++)
        begin
            rails = sysf_rails_t'(14'h0001 << i);
            chk_rd("fault", `SYSF_FAULT_ADDR, 0,
                   ftab[i]);
            `CHK("pg_sum", 1'b1, pg_fault_sum_q)
        end
        rails = '0;
        chk_rd("fault0", `SYSF_FAULT_ADDR, 0, 16'h0000);
        `CHK("pg_sum0", 1'b0, pg_fault_sum_q)
        clk_ratio = 4'h7;
        top_state = `SYSF_ST_OFFSET_ON;
        u_sysf_host_model.wr(`SYSF_GS1_ADDR, 16'hffff);
        u_sysf_host_model.wr(`SYSF_FAULT_ADDR, 16'hffff);
        `CHK("wr_rvalid", 1'b0, rvalid_q)
        `CHK("wr_rdata", 16'h0000, rdata_q)
        chk_rd("gs1_wr", `SYSF_GS1_ADDR, 0, 16'h70a9);
        chk_rd("fault_wr", `SYSF_FAULT_ADDR, 0, 16'h0000);
        // Mid-run reset drops the stored cause and the sticky flags
        conv_evt = sysf_conv_t'(8'h80);
        @(posedge mclk);
        #1;
        conv_evt = '0;
        reset_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        chk_rd("gs1_rst2", `SYSF_GS1_ADDR, 0, 16'h7009);
        chk_rd("conv_rst2", `SYSF_CONV_ADDR, 0, 16'h0000);
        `CHK("conv_sum_rst2", 1'b0, conv_err_sum_q)
        chk_rd("unmapped", 8'h00, 0, 16'h0000);
        report_and_stop();
    end
endmodule

`undef CHK
`default_nettype wire
